// *** tpdc_pkg.sv ***
// Constants and types for the tape position and diagnostic command block
package tpdc_pkg;
    // ----------------------------------------------------------------
    // Opcodes and sense values
    // ----------------------------------------------------------------
    localparam logic [7:0]  OP_RBUF     = 8'h3C;
    localparam logic [7:0]  OP_POS      = 8'h34;
    localparam logic [7:0]  OP_RDIAG    = 8'h1C;
    localparam logic [3:0]  KEY_NONE    = 4'h0;
    localparam logic [3:0]  KEY_NREADY  = 4'h2;
    localparam logic [3:0]  KEY_ILLEGAL = 4'h5;
    localparam logic [3:0]  KEY_ABORT   = 4'hB;
    localparam logic [7:0]  ASC_NOMED   = 8'h3A;
    localparam logic [7:0]  ASCQ_NOMED  = 8'h00;
    // ----------------------------------------------------------------
    // Lengths
    // ----------------------------------------------------------------
    localparam logic [17:0] IMG_LEN     = 18'h2AE28;
    localparam logic [17:0] POS_LEN     = 18'h00014;
    localparam logic [15:0] TRACE_LEN   = 16'h0500;
    // ----------------------------------------------------------------
    // Register offsets and fields
    // ----------------------------------------------------------------
    localparam logic [4:0]  OFS_CDB0    = 5'h00;
    localparam logic [4:0]  OFS_CDB1    = 5'h04;
    localparam logic [4:0]  OFS_CDB2    = 5'h08;
    localparam logic [4:0]  OFS_CTRL    = 5'h0C;
    localparam logic [4:0]  OFS_STAT    = 5'h10;
    localparam logic [4:0]  OFS_XCNT    = 5'h14;
    localparam int          CTRL_START  = 0;
    localparam int          CTRL_CLR    = 1;
    localparam logic [95:0] CDB_RST     = 96'h0;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SRC_POS, SRC_IMG, SRC_DIAG, SRC_TRACE} tpdc_src_e;
    typedef struct packed {
        logic [3:0] key;
        logic [7:0] asc;
        logic [7:0] ascq;
    } tpdc_sense_s;
    localparam tpdc_sense_s SENSE_RST = '{KEY_NONE, 8'h00, 8'h00};
endpackage

// *** tpdc_cmd.sv ***
// Command interpreter for position report, microcode read-back and diag results
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module tpdc_cmd
    import tpdc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cart_loaded,
    input  wire logic        legacy_format,
    input  wire logic        at_lbot,
    input  wire logic        past_leot,
    input  wire logic        pos_unknown,
    input  wire logic [31:0] block_addr,
    input  wire logic        xfer_fault,
    input  wire logic [15:0] diag_len,
    output tpdc_src_e        src_sel,
    output logic      [17:0] src_addr,
    input  wire logic [7:0]  src_data,
    output logic      [7:0]  din_data,
    output logic             din_valid,
    input  wire logic        din_ready
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} tpdc_st_e;
    tpdc_st_e    st;
    logic        ack;
    logic [95:0] cdb;
    logic        busy_done;
    logic        chk;
    tpdc_sense_s sense;
    logic [17:0] xcnt;
    logic [17:0] xlen;
    logic        snap_bop;
    logic        snap_eop;
    logic        snap_bpu;
    logic [31:0] snap_addr;

    // ----------------------------------------------------------------
    // Bus slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    wire req      = avs_read | avs_write;
    wire wr_take  = avs_write & ack;
    wire rd_first = avs_read & ~ack;
    wire sel_ctrl = avs_address == OFS_CTRL;
    assign avs_waitrequest = req & ~ack;

    wire [31:0] stat_word = {8'h00, sense.ascq, sense.asc, sense.key,
                             1'b0, chk, busy_done, st != ST_IDLE};
    wire [31:0] rd_mux =
        (avs_address == OFS_CDB0) ? cdb[31:0]  :
        (avs_address == OFS_CDB1) ? cdb[63:32] :
        (avs_address == OFS_CDB2) ? cdb[95:64] :
        (avs_address == OFS_STAT) ? stat_word  :
        (avs_address == OFS_XCNT) ? {14'h0, xcnt} : 32'h0;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= req & ~ack;
            if (rd_first) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cdb <= CDB_RST;
        end else if (wr_take && avs_address < OFS_CTRL) begin
            for (int i = 0; i < 4; i++) begin
                if (avs_byteenable[i]) begin
                    cdb[avs_address[3:2]*32 + i*8 +: 8] <= avs_writedata[i*8 +: 8];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Descriptor decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] cb(input logic [95:0] c, input int n);
        return c[n*8 +: 8];
    endfunction

    wire [7:0]  op        = cb(cdb, 0);
    wire [7:0]  cdb_b1    = cb(cdb, 1);
    wire [7:0]  cdb_b5    = cb(cdb, 5);
    wire [23:0] rb_field  = {cb(cdb, 6), cb(cdb, 7), cb(cdb, 8)};
    wire        blk_sel   = cdb_b1[0];
    wire [17:0] rb_len    = rb_field[17:0];
    wire [15:0] rd_alloc  = {cb(cdb, 3), cb(cdb, 4)};
    wire        trace_sel = cdb_b5[7];
    wire        rb_bad    = rb_field != {6'h0, IMG_LEN};
    wire [15:0] rd_avail  = trace_sel ? TRACE_LEN : diag_len;
    wire [15:0] rd_cnt    = (rd_alloc < rd_avail) ? rd_alloc : rd_avail;

    // Legacy format beats block type; no cartridge beats both
    wire [3:0] pos_key = !cart_loaded   ? KEY_NREADY  :
                         legacy_format  ? KEY_ILLEGAL :
                         blk_sel        ? KEY_ILLEGAL : KEY_NONE;
    wire [3:0] dec_key = (op == OP_POS)   ? pos_key :
                         (op == OP_RBUF)  ? (rb_bad ? KEY_ILLEGAL : KEY_NONE) :
                         (op == OP_RDIAG) ? KEY_NONE : KEY_ILLEGAL;
    wire [7:0] dec_asc = (op == OP_POS && !cart_loaded) ? ASC_NOMED : 8'h00;
    wire [17:0] dec_len = (op == OP_POS)  ? POS_LEN :
                          (op == OP_RBUF) ? IMG_LEN : {2'b00, rd_cnt};
    wire tpdc_src_e dec_src = (op == OP_POS)  ? SRC_POS :
                              (op == OP_RBUF) ? SRC_IMG :
                              trace_sel ? SRC_TRACE : SRC_DIAG;

    wire start    = wr_take & sel_ctrl & avs_writedata[CTRL_START] & (st == ST_IDLE);
    wire clr_done = wr_take & sel_ctrl & avs_writedata[CTRL_CLR];
    wire dec_chk  = dec_key != KEY_NONE;
    wire no_data  = dec_len == 18'h0;

    // ----------------------------------------------------------------
    // Position response bytes
    // ----------------------------------------------------------------
    function automatic logic [7:0] pos_byte(input logic [17:0] idx, input logic partition_start_flag,
                                            input logic eop, input logic position_unknown_flag,
                                            input logic [31:0] a);
        logic [31:0] av;
        av = position_unknown_flag ? 32'h0 : a;
        case (idx)
            18'd0:   pos_byte = {partition_start_flag, eop, 3'b000, position_unknown_flag, 2'b00};
            18'd4:   pos_byte = av[31:24];
            18'd5:   pos_byte = av[23:16];
            18'd6:   pos_byte = av[15:8];
            18'd7:   pos_byte = av[7:0];
            default: pos_byte = 8'h00;
        endcase
    endfunction

    wire [7:0] next_byte = (src_sel == SRC_POS) ?
                           pos_byte(xcnt, snap_bop, snap_eop, snap_bpu, snap_addr) :
                           src_data;
    wire fault   = (src_sel == SRC_IMG) & xfer_fault & (st != ST_IDLE);
    wire sent    = (st == ST_SEND) & din_ready;
    wire last    = sent & (xcnt + 18'd1 == xlen);
    wire finish  = (start & (dec_chk | no_data)) | fault | last;

    assign din_valid = (st == ST_SEND);
    assign src_addr  = xcnt;

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st        <= ST_IDLE;
            xcnt      <= 18'h0;
            xlen      <= 18'h0;
            src_sel   <= SRC_POS;
            din_data  <= 8'h00;
            chk       <= 1'b0;
            sense     <= SENSE_RST;
            snap_bop  <= 1'b0;
            snap_eop  <= 1'b0;
            snap_bpu  <= 1'b0;
            snap_addr <= 32'h0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (start) begin
                        xcnt    <= 18'h0;
                        xlen    <= dec_len;
                        src_sel <= dec_src;
                        chk     <= dec_chk;
                        sense   <= '{dec_key, dec_asc, ASCQ_NOMED};
                        // Stored position only; no motion request exists
                        snap_bop  <= at_lbot;
                        snap_eop  <= past_leot;
                        snap_bpu  <= pos_unknown;
                        snap_addr <= block_addr;
                        if (!dec_chk && !no_data) begin
                            st <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD: begin
                    din_data <= next_byte;
                    st       <= ST_SEND;
                end
                ST_SEND: begin
                    if (sent) begin
                        xcnt <= xcnt + 18'd1;
                        st   <= last ? ST_IDLE : ST_LOAD;
                    end
                end
                default: st <= ST_IDLE;
            endcase
            if (fault) begin
                st    <= ST_IDLE;
                chk   <= 1'b1;
                sense <= '{KEY_ABORT, 8'h00, 8'h00};
            end
        end
    end

    // Done flag: hardware set wins over software clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_done <= 1'b0;
        end else begin
            busy_done <= finish | (busy_done & ~clr_done & ~start);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb_clk @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_no_cart_sense: assert property (start && op == OP_POS && !cart_loaded
        |=> busy_done && chk && sense.key == 4'h2 && sense.asc == 8'h3A
            && sense.ascq == 8'h00 && st == ST_IDLE)
        else $error("no cartridge sense wrong");
    chk_legacy_illegal: assert property (start && op == OP_POS && cart_loaded
        && legacy_format |=> chk && sense.key == 4'h5 && !din_valid)
        else $error("legacy format not refused");
    chk_rbuf_len: assert property (start && op == OP_RBUF
        && rb_len != 18'h2AE28 |=> chk && sense.key == 4'h5 && st == ST_IDLE)
        else $error("bad read-back length accepted");
    chk_fault_abort: assert property (st != ST_IDLE && src_sel == SRC_IMG
        && xfer_fault |=> st == ST_IDLE && chk && sense.key == 4'hB && busy_done)
        else $error("fault did not abort");
    chk_diag_zero: assert property (start && op == OP_RDIAG && rd_cnt == 0
        |=> !chk && busy_done && !din_valid && xcnt == 18'h0)
        else $error("zero allocation misbehaved");
    chk_xfer_bound: assert property (din_valid |-> xcnt < xlen)
        else $error("transfer past length");
    chk_pos_len: assert property (start && op == OP_POS && !dec_chk
        |=> xlen == 18'd20 ##1 din_valid)
        else $error("position length wrong");
    chk_pos_flags: assert property (din_valid && src_sel == SRC_POS
        && xcnt == 0 |-> din_data[7] == snap_bop && din_data[6] == snap_eop
            && din_data[2] == snap_bpu && din_data[5:3] == 3'b000 && din_data[1:0] == 2'b00)
        else $error("position flag byte wrong");
    chk_pos_zero: assert property (din_valid && src_sel == SRC_POS
        && (xcnt >= 8 || xcnt inside {1, 2, 3}) |-> din_data == 8'h00)
        else $error("position zero field nonzero");
    chk_pos_addr: assert property (din_valid && src_sel == SRC_POS
        && xcnt == 4 && !snap_bpu |-> din_data == snap_addr[31:24])
        else $error("block address byte wrong");
    chk_trace_sel: assert property (start && op == OP_RDIAG && trace_sel
        && rd_alloc >= 16'h0500 |=> xlen == 18'h00500 && src_sel == SRC_TRACE)
        else $error("trace selection wrong");
    chk_img_len: assert property (start && op == OP_RBUF && !rb_bad
        |=> xlen == 18'h2AE28 && !chk && st == ST_LOAD)
        else $error("good read-back length refused");
    chk_pos_unknown: assert property (din_valid && src_sel == SRC_POS
        && snap_bpu && xcnt inside {[4:7]} |-> din_data == 8'h00)
        else $error("address shown while position unknown");
    chk_data_hold: assert property (din_valid && !din_ready
        |=> din_valid && $stable(din_data) && $stable(xcnt))
        else $error("data in byte dropped before taken");
    chk_diag_bound: assert property (start && op == OP_RDIAG
        |=> {2'b00, rd_alloc} >= xlen && {2'b00, rd_avail} >= xlen)
        else $error("diag length above limit");

    cov_pos_done: cover property (last && src_sel == SRC_POS);
    cov_img_abort: cover property (fault);
    cov_trace_done: cover property (last && src_sel == SRC_TRACE);
    cov_diag_empty: cover property (start && op == OP_RDIAG && no_data);
endmodule

// *** tpdc_initiator.sv ***
// Initiator model that takes Data In bytes, with an optional stall pattern
`timescale 1ns/1ns
module tpdc_initiator
    import tpdc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] din_data,
    input  wire logic       din_valid,
    input  wire logic       slow,
    input  wire logic       clr,
    output logic            din_ready,
    output int              rx_cnt
);
    logic [7:0] rx_mem [0:2047];
    logic [1:0] cyc;
    // ----------------------------------------------------------------
    // Ready pattern and capture
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cyc       <= 2'h0;
            din_ready <= 1'b0;
            rx_cnt    <= 0;
        end else begin
            cyc       <= cyc + 2'h1;
            // Slow mode accepts one cycle in four
            din_ready <= !slow || (cyc == 2'h3);
            if (clr) begin
                rx_cnt <= 0;
            end else if (din_valid && din_ready) begin
                rx_mem[rx_cnt[10:0]] <= din_data;
                rx_cnt               <= rx_cnt + 1;
            end
        end
    end
endmodule

// *** tape_position_diag_cmds_test.sv ***
// Self-checking bench for the position, read-back and diagnostic command block
`timescale 1ns/1ns
module tape_position_diag_cmds_test
    import tpdc_pkg::*;
;
    typedef struct packed {
        logic [7:0] op; logic [7:0] b1; logic [23:0] alloc; logic [7:0] b5;
        logic [4:0] st; logic [15:0] elen; logic echk; logic [3:0] ekey; logic [7:0] easc;
    } tpdc_row_s;
    logic ref_clk, resetn, avs_read, avs_write, xfer_fault, din_valid, din_ready, slow, clr;
    logic cart_loaded, legacy_format, at_lbot, past_leot, pos_unknown, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [17:0] src_addr;
    logic [7:0] src_data, din_data, eb;
    tpdc_src_e src_sel;
    int error_cnt, total_checks, rx_cnt, n;
    tpdc_row_s rows [12];
    localparam logic [31:0] ADDR = 32'hA1B2C3D4;
    assign src_data = src_addr[7:0] ^ {src_sel, 6'h00};
    tpdc_cmd dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cart_loaded(cart_loaded),
        .legacy_format(legacy_format), .at_lbot(at_lbot), .past_leot(past_leot),
        .pos_unknown(pos_unknown), .block_addr(ADDR), .xfer_fault(xfer_fault),
        .diag_len(16'h0005), .src_sel(src_sel), .src_addr(src_addr), .src_data(src_data),
        .din_data(din_data), .din_valid(din_valid), .din_ready(din_ready));
    tpdc_initiator initiator (.ref_clk(ref_clk), .resetn(resetn), .din_data(din_data),
        .din_valid(din_valid), .slow(slow), .clr(clr), .din_ready(din_ready),
        .rx_cnt(rx_cnt));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = !ref_clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        int k;
        @(posedge ref_clk);
        avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= d;
        k = 0;
        do begin @(posedge ref_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin error_cnt++; final_report(); end
        q = avs_readdata;
        avs_read <= 1'b0; avs_write <= 1'b0;
    endtask
    task automatic start_cmd(tpdc_row_s r);
        logic [7:0] b3, b4, b6, b7, b8;
        {b3, b4} = (r.op == OP_RBUF) ? 16'h0 : r.alloc[15:0];
        {b6, b7, b8} = (r.op == OP_RBUF) ? r.alloc : 24'h0;
        {cart_loaded, legacy_format, at_lbot, past_leot, pos_unknown} <= r.st;
        clr <= 1'b1;
        bus(1'b1, OFS_CDB0, {b3, 8'h00, r.b1, r.op});
        clr <= 1'b0;
        bus(1'b1, OFS_CDB1, {b7, b6, r.b5, b4});
        bus(1'b1, OFS_CDB2, {24'h0, b8});
        bus(1'b1, OFS_CTRL, 32'h1);
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        do begin bus(1'b0, OFS_STAT, 0); k++; end while (q[1:0] !== 2'b10 && k < 3000);
        if (k >= 3000) begin error_cnt++; final_report(); end
    endtask
    task automatic wait_bytes(int c);
        int k;
        for (k = 0; k < 4000 && rx_cnt < c; k++) @(posedge ref_clk);
        if (k >= 4000) begin error_cnt++; final_report(); end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {resetn, avs_read, avs_write, xfer_fault, slow, clr} = 6'h00;
        {cart_loaded, legacy_format, at_lbot, past_leot, pos_unknown} = 5'h10;
        avs_address = 5'h00; avs_writedata = 32'h0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(1'b0, OFS_STAT, 0); chk("stat rst", 32'h0, q);
        bus(1'b0, OFS_CDB0, 0); chk("cdb0 rst", CDB_RST[31:0], q);
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        bus(1'b0, 5'h1C, 0); chk("unmapped", 32'h0, q);
        rows[0]  = '{OP_POS, 8'h00, 24'h0, 8'h00, 5'b10100, 16'd20, 1'b0, KEY_NONE, 8'h00};
        rows[1]  = '{OP_POS, 8'h00, 24'h0, 8'h00, 5'b10010, 16'd20, 1'b0, KEY_NONE, 8'h00};
        rows[2]  = '{OP_POS, 8'h00, 24'h0, 8'h00, 5'b10001, 16'd20, 1'b0, KEY_NONE, 8'h00};
        rows[3]  = '{OP_POS, 8'h00, 24'h0, 8'h00, 5'b00000, 16'd0, 1'b1, KEY_NREADY, ASC_NOMED};
        rows[4]  = '{OP_POS, 8'h00, 24'h0, 8'h00, 5'b11000, 16'd0, 1'b1, KEY_ILLEGAL, 8'h00};
        rows[5]  = '{OP_POS, 8'h01, 24'h0, 8'h00, 5'b10000, 16'd0, 1'b1, KEY_ILLEGAL, 8'h00};
        rows[6]  = '{OP_RDIAG, 8'h00, 24'h0, 8'h00, 5'b10000, 16'd0, 1'b0, KEY_NONE, 8'h00};
        rows[7]  = '{OP_RDIAG, 8'h00, 24'h3, 8'h00, 5'b10000, 16'd3, 1'b0, KEY_NONE, 8'h00};
        rows[8]  = '{OP_RDIAG, 8'h00, 24'h5, 8'h00, 5'b10000, 16'd5, 1'b0, KEY_NONE, 8'h00};
        rows[9]  = '{OP_RDIAG, 8'h00, 24'h9, 8'h00, 5'b10000, 16'd5, 1'b0, KEY_NONE, 8'h00};
        rows[10] = '{OP_RDIAG, 8'h00, 24'h500, 8'h80, 5'b10000, 16'd1280, 1'b0, KEY_NONE, 8'h00};
        rows[11] = '{OP_RBUF, 8'h01, 24'h2AE27, 8'h00, 5'b10000, 16'd0, 1'b1, KEY_ILLEGAL, 8'h00};
        foreach (rows[i]) begin
            slow <= (i == 10);
            start_cmd(rows[i]);
            wait_done();
            chk("check", rows[i].echk, q[2]);
            chk("sense", {rows[i].ekey, rows[i].easc}, {q[7:4], q[15:8]});
            bus(1'b0, OFS_XCNT, 0);
            chk("xcnt", rows[i].elen, q);
            chk("rx count", rows[i].elen, rx_cnt);
            for (n = 0; n < rx_cnt && n < 2048; n++) begin
                if (rows[i].op == OP_POS)
                    eb = (n == 0) ? {rows[i].st[2:1], 3'b000, rows[i].st[0], 2'b00} :
                         (n > 3 && n < 8 && !rows[i].st[0]) ? ADDR[(7 - n) * 8 +: 8] : 8'h00;
                else
                    eb = n[7:0] ^ {rows[i].b5[7] ? SRC_TRACE : SRC_DIAG, 6'h00};
                chk("data byte", eb, initiator.rx_mem[n]);
            end
        end
        // Read-back aborted by a fault, twice: once after 4 bytes, then again after 10 bytes
        for (n = 0; n < 2; n++) begin
            start_cmd('{OP_RBUF, 8'h01, 24'h2AE28, 8'h00, 5'b10000, 16'd0, 1'b0, KEY_NONE, 8'h00});
            wait_bytes(4 + n * 6);
            xfer_fault <= 1'b1;
            wait_done();
            xfer_fault <= 1'b0;
            chk("fault check", 1'b1, q[2]);
            chk("fault key", KEY_ABORT, q[7:4]);
        end
        // Start while busy is ignored
        slow <= 1'b1;
        start_cmd(rows[10]);
        wait_bytes(10);
        bus(1'b1, OFS_CTRL, 32'h1);
        wait_done();
        chk("busy start rx", 1280, rx_cnt);
        bus(1'b1, OFS_CTRL, 32'h2);
        bus(1'b0, OFS_STAT, 0); chk("done cleared", 1'b0, q[1]);
        // Reset in the middle of a trace transfer
        start_cmd(rows[10]);
        wait_bytes(5);
        resetn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("valid in reset", 1'b0, din_valid);
        chk("rx in reset", 0, rx_cnt);
        resetn <= 1'b1;
        bus(1'b0, OFS_CDB0, 0); chk("cdb0 after reset", CDB_RST[31:0], q);
        bus(1'b0, OFS_STAT, 0); chk("stat after reset", 32'h0, q);
        final_report();
    end
endmodule
